// ===== flash_cmd_host.sv
// Host controller that drives a parallel NOR flash through command sequences
// ------------------------------------------------------------------
// Functional notes
// - Sequence cycles are writes, except id read
// - Reset command leaves query, keeps suspend
// - Reset is one F0 write, any address
// - Unlocks AA@555, 55@2AA; erase 80, 10
// - Query refused while program or erase runs
// - Program: two unlocks, set-up, address/data
// - Bypass entry 20h; bypass program A0h, data
// - Chip erase is six writes
// ------------------------------------------------------------------
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_host (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [19:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_byte_n,
  output logic fl_reset_n,
  input wire logic fl_ready_busy
);
  typedef enum logic [4:0] {
    M_IDLE = 5'b00001, M_ISSUE = 5'b00010, M_WAIT = 5'b00100,
    M_RST = 5'b01000, M_REC = 5'b10000
  } mst_t;

  // ----------------------------------------------------------------
  // Sequence table
  // ----------------------------------------------------------------
  function automatic flash_seq_pkg::cyc_t step_cyc(input flash_seq_pkg::op_t op,
      input logic [2:0] step, input logic byte_m, input logic [19:0] a,
      input logic [15:0] d);
    logic [19:0] u1;
    logic [19:0] u2;
    logic [19:0] ida;
    flash_seq_pkg::cyc_t c;
    u1 = byte_m ? flash_seq_pkg::UA1_B : flash_seq_pkg::UA1_W;
    u2 = byte_m ? flash_seq_pkg::UA2_B : flash_seq_pkg::UA2_W;
    // Id offsets double in byte mode; page select and low bits stay zero
    ida = 20'h00000;
    case (op)
      flash_seq_pkg::OP_ID_DEV: ida[1:0] = flash_seq_pkg::ID_DEV_OFS;
      flash_seq_pkg::OP_ID_PROT: begin
        // Sector bits go in word position here; byte mode shifts them below
        ida = {1'b0, byte_m ? a[19:13] : a[18:12], 12'h000};
        ida[1:0] = flash_seq_pkg::ID_PROT_OFS;
      end
      default: ida[1:0] = flash_seq_pkg::ID_MAN_OFS;
    endcase
    if (byte_m) begin
      ida = {ida[18:0], 1'b0};
    end
    // Command cycles keep upper lanes and unused address lines at zero
    c = '{last: 1'b0, wr: 1'b1, addr: u1, data: {8'h00, flash_seq_pkg::D_UNLOCK1}};
    case (op)
      flash_seq_pkg::OP_READ: c = '{1'b1, 1'b0, a, 16'h0000};
      flash_seq_pkg::OP_RESET: c = '{1'b1, 1'b1, 20'h00000, {8'h00, flash_seq_pkg::D_RESET}};
      flash_seq_pkg::OP_ID_MAN, flash_seq_pkg::OP_ID_DEV, flash_seq_pkg::OP_ID_PROT: begin
        if (step == 3'h1) c = '{1'b0, 1'b1, u2, {8'h00, flash_seq_pkg::D_UNLOCK2}};
        if (step == 3'h2) c = '{1'b0, 1'b1, u1, {8'h00, flash_seq_pkg::D_QUERY}};
        if (step == 3'h3) c = '{1'b1, 1'b0, ida, 16'h0000};
      end
      flash_seq_pkg::OP_PROG: begin
        if (step == 3'h1) c = '{1'b0, 1'b1, u2, {8'h00, flash_seq_pkg::D_UNLOCK2}};
        if (step == 3'h2) c = '{1'b0, 1'b1, u1, {8'h00, flash_seq_pkg::D_PROG}};
        if (step == 3'h3) c = '{1'b1, 1'b1, a, d};
      end
      flash_seq_pkg::OP_BYP_ENTER: begin
        if (step == 3'h1) c = '{1'b0, 1'b1, u2, {8'h00, flash_seq_pkg::D_UNLOCK2}};
        if (step == 3'h2) c = '{1'b1, 1'b1, u1, {8'h00, flash_seq_pkg::D_BYP}};
      end
      flash_seq_pkg::OP_BYP_PROG: begin
        c = '{1'b0, 1'b1, 20'h00000, {8'h00, flash_seq_pkg::D_PROG}};
        if (step == 3'h1) c = '{1'b1, 1'b1, a, d};
      end
      flash_seq_pkg::OP_BYP_EXIT: begin
        c = '{1'b0, 1'b1, 20'h00000, {8'h00, flash_seq_pkg::D_QUERY}};
        if (step == 3'h1) c = '{1'b1, 1'b1, 20'h00000, {8'h00, flash_seq_pkg::D_BYP_EXIT}};
      end
      flash_seq_pkg::OP_CHIP: begin
        if (step == 3'h1 || step == 3'h4) c = '{1'b0, 1'b1, u2, {8'h00, flash_seq_pkg::D_UNLOCK2}};
        if (step == 3'h2) c = '{1'b0, 1'b1, u1, {8'h00, flash_seq_pkg::D_ERASE_SET}};
        if (step == 3'h5) c = '{1'b1, 1'b1, u1, {8'h00, flash_seq_pkg::D_CHIP}};
      end
      flash_seq_pkg::OP_SUSP: c = '{1'b1, 1'b1, 20'h00000, {8'h00, flash_seq_pkg::D_SUSP}};
      flash_seq_pkg::OP_RESUME: c = '{1'b1, 1'b1, 20'h00000, {8'h00, flash_seq_pkg::D_RESUME}};
      default: c = '{1'b1, 1'b0, a, 16'h0000};
    endcase
    return c;
  endfunction : step_cyc

  // Which commands the flash would honour in the mode the host tracks
  function automatic logic legal(input flash_seq_pkg::op_t op, input logic query,
      input logic byp, input logic susp, input logic alg, input logic erase);
    logic ok;
    ok = 1'b0;
    case (op)
      flash_seq_pkg::OP_HWRST: ok = 1'b1;
      // Only a sector erase may be suspended, and this host starts none
      flash_seq_pkg::OP_SUSP: ok = 1'b0 && alg && erase && !susp;
      flash_seq_pkg::OP_RESUME: ok = susp && !alg && !query;
      flash_seq_pkg::OP_READ, flash_seq_pkg::OP_RESET: ok = !alg && !byp;
      flash_seq_pkg::OP_ID_MAN, flash_seq_pkg::OP_ID_DEV, flash_seq_pkg::OP_ID_PROT:
        ok = !alg && !byp;
      flash_seq_pkg::OP_PROG: ok = !alg && !byp && !query;
      flash_seq_pkg::OP_BYP_PROG, flash_seq_pkg::OP_BYP_EXIT: ok = !alg && byp;
      flash_seq_pkg::OP_BYP_ENTER, flash_seq_pkg::OP_CHIP: ok = !alg && !byp && !query && !susp;
      default: ok = 1'b0;
    endcase
    if (op == flash_seq_pkg::OP_READ && byp && !alg) ok = 1'b1;
    return ok;
  endfunction : legal

  mst_t st_q, st_d;
  flash_seq_pkg::op_t op_q, op_d;
  logic [2:0] step_q, step_d;
  logic byte_q, byte_d, query_q, query_d, byp_q, byp_d, susp_q, susp_d;
  logic alg_q, alg_d, erase_q, erase_d, refused_q, refused_d, rst_n_d;
  logic [7:0] cnt_q, cnt_d;
  logic [19:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d, cyc_rdata;
  logic [31:0] rd_d;
  logic rb_s1_q, rb_s2_q, cyc_start, cyc_done, cmd_go;
  flash_seq_pkg::cyc_t cur;

  assign cur = step_cyc(op_q, step_q, byte_q, addr_q, wdata_q);
  assign cyc_start = (st_q == M_ISSUE);
  assign cmd_go = reg_wr && (reg_addr == flash_seq_pkg::REG_CMD) && (st_q == M_IDLE) &&
      legal(flash_seq_pkg::op_t'(reg_wdata[3:0]), query_q, byp_q, susp_q, alg_q, erase_q);
  assign fl_byte_n = ~byte_q;

  flash_bus_cycle u_cyc (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(cyc_start),
    .wr(cur.wr),
    .addr(cur.addr),
    .wdata(cur.data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

  // ----------------------------------------------------------------
  // Sequencer and mode tracking
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    step_d = step_q;
    byte_d = byte_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    query_d = query_q;
    byp_d = byp_q;
    susp_d = susp_q;
    alg_d = alg_q;
    erase_d = erase_q;
    refused_d = refused_q;
    rst_n_d = fl_reset_n;
    cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
    // Ready/busy is ignored until its own delay has passed after the last write
    if (alg_q && st_q == M_IDLE && cnt_q == 8'h00 && rb_s2_q) begin
      alg_d = 1'b0;
    end
    if (reg_wr && reg_addr == flash_seq_pkg::REG_CTRL) byte_d = reg_wdata[0];
    if (reg_wr && reg_addr == flash_seq_pkg::REG_ADDR) addr_d = reg_wdata[19:0];
    if (reg_wr && reg_addr == flash_seq_pkg::REG_WDATA) wdata_d = reg_wdata[15:0];
    if (reg_wr && reg_addr == flash_seq_pkg::REG_STATUS && reg_wdata[flash_seq_pkg::ST_REFUSED]) begin
      refused_d = 1'b0;
    end
    // A refused command sets the flag even in the cycle software clears it
    if (reg_wr && reg_addr == flash_seq_pkg::REG_CMD && !cmd_go) refused_d = 1'b1;
    case (st_q)
      M_IDLE: begin
        if (cmd_go) begin
          op_d = flash_seq_pkg::op_t'(reg_wdata[3:0]);
          step_d = 3'h0;
          if (query_q && reg_wdata[3:0] inside {flash_seq_pkg::OP_ID_MAN,
              flash_seq_pkg::OP_ID_DEV, flash_seq_pkg::OP_ID_PROT}) begin
            step_d = flash_seq_pkg::ID_READ_STEP;
          end
          if (reg_wdata[3:0] == flash_seq_pkg::OP_HWRST) begin
            rst_n_d = 1'b0;
            cnt_d = 8'(flash_seq_pkg::T_RP_CYC - 1);
            st_d = M_RST;
          end else begin
            st_d = M_ISSUE;
          end
        end
      end
      M_ISSUE: st_d = M_WAIT;
      M_WAIT: begin
        if (cyc_done) begin
          if (!cur.last) begin
            step_d = step_q + 3'h1;
            st_d = M_ISSUE;
          end else begin
            st_d = M_IDLE;
            if (!cur.wr) rdata_d = cyc_rdata;
            case (op_q)
              flash_seq_pkg::OP_RESET: query_d = 1'b0;
              flash_seq_pkg::OP_ID_MAN, flash_seq_pkg::OP_ID_DEV,
              flash_seq_pkg::OP_ID_PROT: query_d = 1'b1;
              flash_seq_pkg::OP_BYP_ENTER: byp_d = 1'b1;
              flash_seq_pkg::OP_BYP_EXIT: byp_d = 1'b0;
              flash_seq_pkg::OP_SUSP: susp_d = 1'b1;
              flash_seq_pkg::OP_PROG, flash_seq_pkg::OP_BYP_PROG: begin
                alg_d = 1'b1;
                erase_d = 1'b0;
              end
              flash_seq_pkg::OP_CHIP, flash_seq_pkg::OP_RESUME: begin
                alg_d = 1'b1;
                erase_d = 1'b1;
                susp_d = 1'b0;
              end
              default: alg_d = alg_q;
            endcase
            // The erase stays owned by the suspend until resumed
            if (op_q == flash_seq_pkg::OP_PROG && susp_q) erase_d = 1'b1;
            cnt_d = 8'(flash_seq_pkg::T_BUSY_CYC - 1);
          end
        end
      end
      M_RST: begin
        if (cnt_q == 8'h00) begin
          rst_n_d = 1'b1;
          cnt_d = 8'(flash_seq_pkg::T_RH_CYC - 1);
          st_d = M_REC;
        end
      end
      M_REC: begin
        query_d = 1'b0;
        byp_d = 1'b0;
        susp_d = 1'b0;
        alg_d = 1'b0;
        erase_d = 1'b0;
        if (cnt_q == 8'h00) st_d = M_IDLE;
      end
      default: st_d = M_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        flash_seq_pkg::REG_CTRL: rd_d = {31'h00000000, byte_q};
        flash_seq_pkg::REG_ADDR: rd_d = {12'h000, addr_q};
        flash_seq_pkg::REG_WDATA: rd_d = {16'h0000, wdata_q};
        flash_seq_pkg::REG_CMD: rd_d = {28'h0000000, op_q};
        flash_seq_pkg::REG_STATUS: rd_d = {24'h000000, byte_q, rb_s2_q, refused_q, susp_q,
            byp_q, query_q, alg_q, (st_q != M_IDLE) || alg_q};
        flash_seq_pkg::REG_RDATA: rd_d = {16'h0000, rdata_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= M_IDLE;
      op_q <= flash_seq_pkg::OP_READ;
      step_q <= 3'h0;
      byte_q <= flash_seq_pkg::BYTE_RST;
      addr_q <= 20'h00000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      query_q <= 1'b0;
      byp_q <= 1'b0;
      susp_q <= 1'b0;
      alg_q <= 1'b0;
      erase_q <= 1'b0;
      refused_q <= 1'b0;
      fl_reset_n <= 1'b1;
      cnt_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
      reg_rdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      step_q <= step_d;
      byte_q <= byte_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      query_q <= query_d;
      byp_q <= byp_d;
      susp_q <= susp_d;
      alg_q <= alg_d;
      erase_q <= erase_d;
      refused_q <= refused_d;
      fl_reset_n <= rst_n_d;
      cnt_q <= cnt_d;
      rb_s1_q <= fl_ready_busy;
      rb_s2_q <= rb_s1_q;
      reg_rdata <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_cmd_a: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && op_q == flash_seq_pkg::OP_RESET |-> cur.wr && cur.data == 16'h00f0)
    else $error("reset command cycle malformed");
  unlock_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && op_q == flash_seq_pkg::OP_PROG && step_q == 3'h1 && !byte_q
    |-> cur.addr == 20'h002aa && cur.data == 16'h0055 && $past(step_q) == 3'h0)
    else $error("second unlock cycle wrong");
  id_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && step_q == 3'h3 && op_q inside {flash_seq_pkg::OP_ID_MAN,
    flash_seq_pkg::OP_ID_DEV, flash_seq_pkg::OP_ID_PROT} |-> !cur.wr ##1 (!fl_dq_oe)[*4])
    else $error("id cycle is not a read");
  query_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == M_WAIT && cyc_done && op_q == flash_seq_pkg::OP_RESET
    |=> !query_q && susp_q == $past(susp_q))
    else $error("reset did not leave query mode");
  query_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == flash_seq_pkg::REG_CMD && alg_q &&
    reg_wdata[3:0] == flash_seq_pkg::OP_ID_MAN |=> refused_q && st_q == M_IDLE)
    else $error("query accepted while busy");
  prog_data_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == M_WAIT && cyc_done && op_q == flash_seq_pkg::OP_PROG && step_q == 3'h3
    |=> alg_q && st_q == M_IDLE)
    else $error("program did not start algorithm");
  bypass_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && op_q == flash_seq_pkg::OP_BYP_ENTER && step_q == 3'h2
    |-> cur.data == 16'h0020 && cur.last)
    else $error("bypass entry code wrong");
  chip_erase_a: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && op_q == flash_seq_pkg::OP_CHIP && step_q == 3'h5
    |-> cur.data == 16'h0010 && cur.last && !byp_q)
    else $error("chip erase final cycle wrong");
  upper_lane_a: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && cur.wr && !cur.last |-> cur.data[15:8] == 8'h00)
    else $error("upper lanes driven in command cycle");
endmodule : flash_cmd_host
`default_nettype wire

// ===== flash_seq_pkg.sv
// Shared constants and types for the flash command host
package flash_seq_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int SYNC_CYC = 2;
  localparam int T_AS_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 70;
  localparam int T_BUSY_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 200;
  localparam int T_AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int T_BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int T_RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_CMD = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_RDATA = 3'h5;
  localparam int ST_REFUSED = 5;
  localparam logic BYTE_RST = 1'b0;
  // ----------------------------------------------------------------
  // Flash command codes and unlock addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] D_UNLOCK1 = 8'haa;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_RESET = 8'hf0;
  localparam logic [7:0] D_QUERY = 8'h90;
  localparam logic [7:0] D_PROG = 8'ha0;
  localparam logic [7:0] D_BYP = 8'h20;
  localparam logic [7:0] D_ERASE_SET = 8'h80;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SUSP = 8'hb0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_BYP_EXIT = 8'h00;
  localparam logic [19:0] UA1_W = 20'h00555;
  localparam logic [19:0] UA2_W = 20'h002aa;
  localparam logic [19:0] UA1_B = 20'h00aaa;
  localparam logic [19:0] UA2_B = 20'h00555;
  localparam logic [1:0] ID_MAN_OFS = 2'h0;
  localparam logic [1:0] ID_DEV_OFS = 2'h1;
  localparam logic [1:0] ID_PROT_OFS = 2'h2;
  localparam logic [2:0] ID_READ_STEP = 3'h3;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_ID_MAN = 4'h2, OP_ID_DEV = 4'h3,
    OP_ID_PROT = 4'h4, OP_PROG = 4'h5, OP_BYP_ENTER = 4'h6, OP_BYP_PROG = 4'h7,
    OP_BYP_EXIT = 4'h8, OP_CHIP = 4'h9, OP_SUSP = 4'ha, OP_RESUME = 4'hb,
    OP_HWRST = 4'hc
  } op_t;
  typedef struct packed {
    logic last;
    logic wr;
    logic [19:0] addr;
    logic [15:0] data;
  } cyc_t;
endpackage : flash_seq_pkg

// ===== flash_bus_cycle.sv
// One timed read or write cycle on the flash pins
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic wr,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  output logic [19:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001, C_SET = 4'b0010, C_PUL = 4'b0100, C_HLD = 4'b1000
  } cst_t;
  cst_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic wr_q, wr_d, done_d, ce_d, we_d, oe_d, dqoe_d;
  logic [19:0] addr_d;
  logic [15:0] dout_d, rdata_d, dq_s1_q, dq_s2_q;

  // ----------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = fl_addr;
    dout_d = fl_dq_o;
    rdata_d = rdata;
    ce_d = fl_ce_n;
    we_d = fl_we_n;
    oe_d = fl_oe_n;
    dqoe_d = fl_dq_oe;
    done_d = 1'b0;
    case (st_q)
      C_IDLE: begin
        if (start) begin
          addr_d = addr;
          dout_d = wdata;
          wr_d = wr;
          ce_d = 1'b0;
          dqoe_d = wr;
          cnt_d = 8'(flash_seq_pkg::T_AS_CYC - 1);
          st_d = C_SET;
        end
      end
      C_SET: begin
        if (cnt_q == 8'h00) begin
          we_d = ~wr_q;
          oe_d = wr_q;
          cnt_d = wr_q ? 8'(flash_seq_pkg::T_WP_CYC - 1) : 8'(flash_seq_pkg::T_ACC_CYC - 1);
          st_d = C_PUL;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      C_PUL: begin
        if (cnt_q == 8'h00) begin
          we_d = 1'b1;
          oe_d = 1'b1;
          if (!wr_q) begin
            rdata_d = dq_s2_q;
          end
          cnt_d = 8'(flash_seq_pkg::T_WPH_CYC - 1);
          st_d = C_HLD;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      C_HLD: begin
        // Write data stays on the bus past the rising strobe for hold time
        if (cnt_q == 8'h00) begin
          ce_d = 1'b1;
          dqoe_d = 1'b0;
          done_d = 1'b1;
          st_d = C_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: st_d = C_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= C_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      fl_addr <= 20'h00000;
      fl_dq_o <= 16'h0000;
      rdata <= 16'h0000;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_dq_oe <= 1'b0;
      done <= 1'b0;
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      fl_addr <= addr_d;
      fl_dq_o <= dout_d;
      rdata <= rdata_d;
      fl_ce_n <= ce_d;
      fl_we_n <= we_d;
      fl_oe_n <= oe_d;
      fl_dq_oe <= dqoe_d;
      done <= done_d;
      dq_s1_q <= fl_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end
endmodule : flash_bus_cycle
`default_nettype wire

// ===== flash_model.sv
// Behavioural parallel flash seen by the host
`timescale 1ns/10ps
`default_nettype none
module flash_model #(parameter logic [7:0] MAN = 8'h0, DEV = 8'h0) (
  input wire logic [19:0] a,
  input wire logic [15:0] d,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rst_n,
  input wire logic drv,
  output logic [15:0] q,
  output logic rb
);
  logic [15:0] mem [int];
  int st = 0;
  bit id = 0, byp = 0, er = 0;
  wire logic [7:0] c = d[7:0];
  initial q = 16'h0;
  initial rb = 1'b1;
  // A released bus flips so a stale value never passes for read data
  always @(oe_n or ce_n or a)
    if (oe_n || ce_n) q = ~q;
    else if (id) q = (a[1:0] == 2'h0) ? MAN : (a[1:0] == 2'h1) ? DEV : 16'h0;
    else q = mem.exists(a[18:0]) ? mem[a[18:0]] : 16'hffff;
  always @(posedge we_n or negedge rst_n)
    if (!rst_n) begin
      {st, id, byp, er} = 0;
      rb = 1'b1;
    end else if (!ce_n && rb && drv) begin
      if (c == 8'hf0 && st != 3) {st, id, er} = 0;
      else if (st == 3) begin
        mem[a[18:0]] = (mem.exists(a[18:0]) ? mem[a[18:0]] : 16'hffff) & d;
        st = 0;
        rb = 1'b0;
      end else if (byp) begin
        if (st == 4) byp = c != 8'h00;
        st = (c == 8'ha0) ? 3 : (c == 8'h90) ? 4 : 0;
      end else if (st == 0) st = (a[10:0] == 11'h555 && c == 8'haa) ? 1 : 0;
      else if (st == 1) st = (a[10:0] == 11'h2aa && c == 8'h55) ? 2 : 0;
      else begin
        id = id | (c == 8'h90);
        byp = c == 8'h20;
        if (er && c == 8'h10) begin
          mem.delete();
          rb = 1'b0;
        end
        er = c == 8'h80;
        st = (c == 8'ha0) ? 3 : 0;
      end
    end
  // Busy time is a plain figure; the host must wait on the line, not a count
  always @(negedge rb) #400 rb = 1'b1;
endmodule : flash_model
`default_nettype wire

// ===== flash_command_sequencer_bench.sv
// Self-checking bench for the flash command host
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_bench;
  localparam logic [7:0] MAN = 8'h3c, DEV = 8'hc3; // Arbitrary identity values
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ce_n, we_n, oe_n, rst_n, rb, drv, byte_n;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [19:0] fa, a;
  logic [15:0] dq_o, dq_i, d1;
  logic [15:0] ref_mem [int];
  int miscompares = 0, n_checks = 0, seed = 32'hbae7;
  flash_cmd_host i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fl_addr(fa), .fl_dq_o(dq_o), .fl_dq_oe(drv), .fl_dq_i(dq_i), .fl_ce_n(ce_n),
    .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_byte_n(byte_n), .fl_reset_n(rst_n),
    .fl_ready_busy(rb));
  flash_model #(.MAN(MAN), .DEV(DEV)) i_flash (.a(fa), .d(dq_o), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .rst_n(rst_n), .drv(drv), .q(dq_i), .rb(rb));
  initial forever #4 clk = ~clk;
  task automatic wr(input logic [2:0] ra, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= ra;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] ra);
    @(posedge clk);
    reg_addr <= ra;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Polls busy; a refused command simply never raises it
  task automatic cmd(input logic [3:0] op);
    int i;
    wr(3'h3, {28'h0, op});
    for (i = 0; i < 3000; i++) begin
      rd(3'h4);
      if (v[0] === 1'b0) break;
    end
    if (i == 3000) miscompares++;
  endtask : cmd
  task automatic acc(input logic [3:0] op, input logic [15:0] d, input logic [15:0] e);
    wr(3'h1, {12'h0, a});
    wr(3'h2, {16'h0, d});
    cmd(op);
    rd(3'h5);
    if (op == 4'h5 || op == 4'h7) ref_mem[a] = (ref_mem.exists(a) ? ref_mem[a] : 16'hffff) & d;
    else chk("rdata", {16'h0, e}, v);
  endtask : acc
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    a = 20'($random(seed)) & 20'h3fff0;
    d1 = 16'($random(seed));
    wr(3'h0, 32'h1);
    rd(3'h4);
    chk("byte_mode", 32'hc0, (v & 32'hfe) | {31'h0, byte_n});
    wr(3'h0, 32'h0);
    acc(4'h0, 16'h0, 16'hffff);
    acc(4'h5, d1, 16'h0);
    acc(4'h5, 16'($random(seed)), 16'h0);
    acc(4'h0, 16'h0, ref_mem[a]);
    wr(3'h3, 32'h9);
    do rd(3'h4); while (v[1] !== 1'b1);
    wr(3'h3, 32'h2);
    rd(3'h4);
    chk("busy_id", 32'h22, v & 32'h26);
    wr(3'h4, 32'h20);
    wr(3'h3, 32'ha);
    rd(3'h4);
    chk("busy_susp", 32'h22, v & 32'h32);
    wr(3'h4, 32'h20);
    do rd(3'h4); while (v[0] !== 1'b0);
    ref_mem.delete();
    acc(4'h0, 16'h0, 16'hffff);
    acc(4'h2, 16'h0, {8'h0, MAN});
    acc(4'h3, 16'h0, {8'h0, DEV});
    acc(4'h4, 16'h0, 16'h0);
    cmd(4'h5);
    rd(3'h4);
    chk("refused", 32'h20, v & 32'h20);
    wr(3'h4, 32'h20);
    cmd(4'h1);
    cmd(4'h6);
    a = a + 20'h10;
    acc(4'h7, d1, 16'h0);
    cmd(4'h8);
    acc(4'h0, 16'h0, d1);
    cmd(4'h6);
    cmd(4'hc);
    rd(3'h4);
    chk("hwrst", 32'h40, v & 32'h5f);
    acc(4'h2, 16'h0, {8'h0, MAN});
    rd(3'h7);
    chk("unmapped", 32'h0, v);
    tally_and_finish;
  end
  initial begin
    #400000;
    miscompares++;
    tally_and_finish;
  end
endmodule : flash_command_sequencer_bench
`default_nettype wire
